//--- hw/sfl_flash_port.sv
// Serial flash command port: reads, status byte, write latch
`timescale 1ns/1ps
module sfl_flash_port #(
  parameter int STATUS_WRITE_CYCLES = sfl_pkg::STATUS_WRITE_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic write_guard_n,
  input wire logic serial_in_io0_in,
  output logic serial_in_io0_out,
  output logic serial_in_io0_oe_n,
  input wire logic serial_out_io1_in,
  output logic serial_out_io1_out,
  output logic serial_out_io1_oe_n,
  output logic [18:0] mem_rd_addr,
  input wire logic mem_rd_valid,
  output logic mem_rd_ready,
  input wire logic [7:0] mem_rd_data,
  input wire logic ext_busy,
  input wire logic ext_write_done,
  input wire logic [7:0] nv_bits_in,
  output logic [7:0] nv_bits_out,
  output logic nv_store,
  output logic write_latch,
  output logic write_in_progress,
  output logic spi_mode3
);
  localparam int CNT_W = $clog2(STATUS_WRITE_CYCLES + 1);
  localparam logic [CNT_W-1:0] BUSY_LAST =
    CNT_W'(STATUS_WRITE_CYCLES - 1);

  sfl_pkg::sfl_state_e state_reg;
  logic [4:0] s_pins;
  logic s_cs_n, s_sck, s_io0, s_io1, s_guard_n;
  logic sck_prev_reg, cs_prev_reg;
  logic sck_rise, sck_fall, cs_fall, cs_rise;
  logic [4:0] bit_cnt_reg;
  logic [23:0] shift_reg;
  logic [23:0] shift_next;
  logic [7:0] opcode_reg;
  logic [7:0] opcode_now;
  logic dual_in_reg, dual_out_reg, cmd_ok_reg;
  logic [7:0] wr_data_reg;
  logic fetch_start, fetch_active_reg;
  logic buf_in_ready, buf_out_valid, buf_pop;
  logic [7:0] buf_data;
  logic [7:0] out_shift_reg;
  logic [2:0] out_left_reg;
  logic [2:0] st_idx_reg;
  logic latch_reg, sw_busy_reg, nv_load_reg;
  logic [CNT_W-1:0] busy_cnt_reg;
  logic [7:0] nv_reg;
  logic [7:0] status_byte;
  logic latch_set, latch_clr, wr_start, wr_done, wr_locked;

  ////////////////////////////////////////////////////////////////////////
  // Pin capture and edge detection

  sfl_sync2 #(
    .WIDTH(5),
    .RESET_VAL(5'h11)
  ) u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .async_in({chip_select_n, serial_clock, serial_in_io0_in,
               serial_out_io1_in, write_guard_n}),
    .sync_out(s_pins)
  );

  assign {s_cs_n, s_sck, s_io0, s_io1, s_guard_n} = s_pins;

  // Previous levels for edge finding, taken from the second stage only
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sck_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
    end else begin
      sck_prev_reg <= s_sck;
      cs_prev_reg <= s_cs_n;
    end
  end

  assign sck_rise = s_sck & ~sck_prev_reg & ~s_cs_n;
  assign sck_fall = ~s_sck & sck_prev_reg & ~s_cs_n;
  assign cs_fall = ~s_cs_n & cs_prev_reg;
  assign cs_rise = s_cs_n & ~cs_prev_reg;

  // Clock level at select picks the mode; in mode 3 the first edge
  // is a fall, which the command phase simply ignores
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      spi_mode3 <= 1'b0;
    end else if (cs_fall) begin
      spi_mode3 <= s_sck;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command sequencer on rising clock edges

  // MSB-first shifting, two lanes at once during a dual address phase
  always_comb begin
    if (state_reg == sfl_pkg::ST_ADDR && dual_in_reg) begin
      shift_next = {shift_reg[21:0], s_io1, s_io0};
    end else begin
      shift_next = {shift_reg[22:0], s_io0};
    end
  end

  assign opcode_now = shift_next[7:0];
  assign fetch_start = sck_rise && state_reg == sfl_pkg::ST_ADDR &&
    bit_cnt_reg == (dual_in_reg ? sfl_pkg::DUAL_ADDR_CLKS :
                    sfl_pkg::SINGLE_ADDR_CLKS) - 5'h01;

  // Deselect forces idle, so a partial header leaves no trace
  always_ff @(posedge clock) begin
    if (sys_rst || s_cs_n) begin
      state_reg <= sfl_pkg::ST_IDLE;
    end else if (cs_fall) begin
      state_reg <= sfl_pkg::ST_CMD;
    end else if (sck_rise) begin
      case (state_reg)
        sfl_pkg::ST_CMD: begin
          if (bit_cnt_reg == sfl_pkg::OPCODE_CLKS - 5'h01) begin
            case (opcode_now)
              sfl_pkg::OP_FAST_READ: state_reg <= sfl_pkg::ST_ADDR;
              sfl_pkg::OP_DUAL_OUT: state_reg <= sfl_pkg::ST_ADDR;
              sfl_pkg::OP_DUAL_IO: state_reg <= sfl_pkg::ST_ADDR;
              sfl_pkg::OP_STATUS_RD: state_reg <= sfl_pkg::ST_STATUS_OUT;
              sfl_pkg::OP_STATUS_WR: state_reg <= sfl_pkg::ST_WR_DATA;
              default: state_reg <= sfl_pkg::ST_IGNORE;
            endcase
          end
        end
        sfl_pkg::ST_ADDR: begin
          if (fetch_start) begin
            state_reg <= sfl_pkg::ST_DUMMY;
          end
        end
        sfl_pkg::ST_DUMMY: begin
          if (bit_cnt_reg == (dual_in_reg ? sfl_pkg::DUAL_DUMMY_CLKS :
              sfl_pkg::SINGLE_DUMMY_CLKS) - 5'h01) begin
            state_reg <= sfl_pkg::ST_DATA_OUT;
          end
        end
        sfl_pkg::ST_WR_DATA: begin
          if (bit_cnt_reg == sfl_pkg::DATA_BYTE_CLKS - 5'h01) begin
            state_reg <= sfl_pkg::ST_IGNORE;
          end
        end
        default: state_reg <= state_reg;
      endcase
    end
  end

  // Bit counter restarts after the opcode and address phases, and is cleared on each rising edge in data out
  always_ff @(posedge clock) begin
    if (sys_rst || cs_fall) begin
      bit_cnt_reg <= 5'h00;
    end else if (sck_rise) begin
      if ((state_reg == sfl_pkg::ST_CMD &&
           bit_cnt_reg == sfl_pkg::OPCODE_CLKS - 5'h01) || fetch_start ||
          state_reg == sfl_pkg::ST_DATA_OUT) begin
        bit_cnt_reg <= 5'h00;
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
    end
  end

  // Header shift, opcode, lane flags and the completed-command flag
  always_ff @(posedge clock) begin
    if (sys_rst || cs_fall) begin
      shift_reg <= 24'h000000;
      opcode_reg <= 8'h00;
      dual_in_reg <= 1'b0;
      dual_out_reg <= 1'b0;
      cmd_ok_reg <= 1'b0;
      wr_data_reg <= 8'h00;
    end else if (sck_rise) begin
      shift_reg <= shift_next;
      if (state_reg == sfl_pkg::ST_CMD &&
          bit_cnt_reg == sfl_pkg::OPCODE_CLKS - 5'h01) begin
        opcode_reg <= opcode_now;
        dual_in_reg <= (opcode_now == sfl_pkg::OP_DUAL_IO);
        dual_out_reg <= (opcode_now == sfl_pkg::OP_DUAL_IO) ||
                        (opcode_now == sfl_pkg::OP_DUAL_OUT);
        cmd_ok_reg <= (opcode_now == sfl_pkg::OP_LATCH_SET) ||
                      (opcode_now == sfl_pkg::OP_LATCH_CLR);
      end
      if (state_reg == sfl_pkg::ST_WR_DATA &&
          bit_cnt_reg == sfl_pkg::DATA_BYTE_CLKS - 5'h01) begin
        wr_data_reg <= opcode_now;
        cmd_ok_reg <= 1'b1;
      end
      // A clock past the data byte breaks byte alignment
      if (state_reg == sfl_pkg::ST_IGNORE &&
          opcode_reg == sfl_pkg::OP_STATUS_WR) begin
        cmd_ok_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Array prefetch through the two-entry buffer

  // Fetch address runs ahead of the shifter and wraps at the top
  always_ff @(posedge clock) begin
    if (sys_rst || s_cs_n) begin
      fetch_active_reg <= 1'b0;
      mem_rd_addr <= sfl_pkg::ADDR_BASE;
    end else if (fetch_start) begin
      fetch_active_reg <= 1'b1;
      mem_rd_addr <= shift_next[sfl_pkg::ADDR_W-1:0];
    end else if (mem_rd_valid && mem_rd_ready) begin
      mem_rd_addr <= (mem_rd_addr == sfl_pkg::ADDR_TOP) ?
        sfl_pkg::ADDR_BASE : mem_rd_addr + 19'h00001;
    end
  end

  assign mem_rd_ready = fetch_active_reg & buf_in_ready;

  sfl_buf2 #(
    .WIDTH(8)
  ) u_buf (
    .clock(clock),
    .sys_rst(sys_rst),
    .flush(fetch_start | s_cs_n),
    .in_valid(mem_rd_valid & fetch_active_reg),
    .in_ready(buf_in_ready),
    .in_data(mem_rd_data),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop),
    .out_data(buf_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Output shifter on falling clock edges

  // An empty buffer at a byte boundary shifts its stale entry at the read pointer; the array must
  // keep up with one byte per eight link clocks, or per four when dual
  assign buf_pop = sck_fall && state_reg == sfl_pkg::ST_DATA_OUT &&
                   out_left_reg == 3'h0;

  always_ff @(posedge clock) begin
    if (sys_rst || s_cs_n || cs_fall) begin
      out_shift_reg <= 8'h00;
      out_left_reg <= 3'h0;
      st_idx_reg <= 3'h7;
      serial_in_io0_out <= 1'b0;
      serial_out_io1_out <= 1'b0;
    end else if (sck_fall && state_reg == sfl_pkg::ST_DATA_OUT) begin
      if (out_left_reg == 3'h0) begin
        serial_in_io0_out <= buf_data[7];
        serial_out_io1_out <= dual_out_reg ? buf_data[6] : buf_data[7];
        out_shift_reg <= dual_out_reg ? {buf_data[5:0], 2'h0} :
                                        {buf_data[6:0], 1'b0};
        out_left_reg <= dual_out_reg ? sfl_pkg::DUAL_PAIR_LAST :
                                       sfl_pkg::SINGLE_BIT_LAST;
      end else begin
        serial_in_io0_out <= out_shift_reg[7];
        serial_out_io1_out <= dual_out_reg ? out_shift_reg[6] :
                                             out_shift_reg[7];
        out_shift_reg <= dual_out_reg ? {out_shift_reg[5:0], 2'h0} :
                                        {out_shift_reg[6:0], 1'b0};
        out_left_reg <= out_left_reg - 3'h1;
      end
    end else if (sck_fall && state_reg == sfl_pkg::ST_STATUS_OUT) begin
      // Index wraps 0 to 7, so the byte repeats endlessly
      serial_out_io1_out <= status_byte[st_idx_reg];
      st_idx_reg <= st_idx_reg - 3'h1;
    end
  end

  // Lanes float unless a data phase has begun driving them
  always_ff @(posedge clock) begin
    if (sys_rst || s_cs_n || cs_fall) begin
      serial_in_io0_oe_n <= 1'b1;
      serial_out_io1_oe_n <= 1'b1;
    end else if (sck_fall && state_reg == sfl_pkg::ST_DATA_OUT) begin
      serial_in_io0_oe_n <= ~dual_out_reg;
      serial_out_io1_oe_n <= 1'b0;
    end else if (sck_fall && state_reg == sfl_pkg::ST_STATUS_OUT) begin
      serial_out_io1_oe_n <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status byte, write latch and status write engine

  assign wr_locked = nv_reg[sfl_pkg::ST_LOCK_BIT] & ~s_guard_n;
  assign latch_set = cs_rise & cmd_ok_reg &
                     (opcode_reg == sfl_pkg::OP_LATCH_SET);
  assign latch_clr = cs_rise & cmd_ok_reg &
                     (opcode_reg == sfl_pkg::OP_LATCH_CLR);
  assign wr_start = cs_rise & cmd_ok_reg &
    (opcode_reg == sfl_pkg::OP_STATUS_WR) & latch_reg &
    ~write_in_progress & ~wr_locked;
  assign wr_done = sw_busy_reg && busy_cnt_reg == '0;

  assign write_in_progress = sw_busy_reg | ext_busy;
  assign write_latch = latch_reg;
  assign nv_bits_out = nv_reg;

  always_comb begin
    status_byte = nv_reg & sfl_pkg::STATUS_WR_MASK;
    status_byte[sfl_pkg::ST_WIP_BIT] = write_in_progress;
    status_byte[sfl_pkg::ST_LATCH_BIT] = latch_reg;
  end

  // Latch: set wins when a set and a completion meet in one cycle;
  // rejected writes and reads never reach these terms
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      latch_reg <= 1'b0;
    end else if (latch_set) begin
      latch_reg <= 1'b1;
    end else if (latch_clr || wr_done || ext_write_done) begin
      latch_reg <= 1'b0;
    end
  end

  // Nonvolatile copy is reloaded after reset; only masked bits change
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      nv_reg <= sfl_pkg::NV_RESET;
      nv_load_reg <= 1'b1;
    end else if (nv_load_reg) begin
      nv_reg <= nv_bits_in & sfl_pkg::STATUS_WR_MASK;
      nv_load_reg <= 1'b0;
    end else if (wr_start) begin
      nv_reg <= wr_data_reg & sfl_pkg::STATUS_WR_MASK;
    end
  end

  // Busy period counted down; completion pulses the store strobe
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sw_busy_reg <= 1'b0;
      busy_cnt_reg <= '0;
      nv_store <= 1'b0;
    end else begin
      nv_store <= wr_done;
      if (wr_start) begin
        sw_busy_reg <= 1'b1;
        busy_cnt_reg <= BUSY_LAST;
      end else if (wr_done) begin
        sw_busy_reg <= 1'b0;
      end else if (sw_busy_reg) begin
        busy_cnt_reg <= busy_cnt_reg - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  property p_desel_float;
    @(posedge clock) disable iff (sys_rst)
    s_cs_n |=> serial_in_io0_oe_n && serial_out_io1_oe_n;
  endproperty
  a_desel_float: assert property (p_desel_float)
    else $error("lanes driven while deselected");

  property p_dummy_float;
    @(posedge clock) disable iff (sys_rst)
    state_reg == sfl_pkg::ST_DUMMY |-> serial_in_io0_oe_n &&
      serial_out_io1_oe_n;
  endproperty
  a_dummy_float: assert property (p_dummy_float)
    else $error("lane driven during dummy clocks");

  property p_latch_set;
    @(posedge clock) disable iff (sys_rst)
    latch_set |=> latch_reg;
  endproperty
  a_latch_set: assert property (p_latch_set)
    else $error("set command did not set latch");

  property p_latch_clr;
    @(posedge clock) disable iff (sys_rst)
    latch_clr |=> !latch_reg;
  endproperty
  a_latch_clr: assert property (p_latch_clr)
    else $error("clear command did not clear latch");

  property p_wip_busy;
    @(posedge clock) disable iff (sys_rst)
    sw_busy_reg |-> status_byte[sfl_pkg::ST_WIP_BIT];
  endproperty
  a_wip_busy: assert property (p_wip_busy)
    else $error("busy flag low during status write");

  property p_done_clears;
    @(posedge clock) disable iff (sys_rst)
    $fell(sw_busy_reg) && !$past(latch_set) |-> !latch_reg && nv_store;
  endproperty
  a_done_clears: assert property (p_done_clears)
    else $error("latch not cleared at write completion");

  property p_locked;
    @(posedge clock) disable iff (sys_rst)
    cs_rise && wr_locked && !sw_busy_reg |=> !sw_busy_reg;
  endproperty
  a_locked: assert property (p_locked)
    else $error("locked status write was started");

  property p_ro_bits;
    @(posedge clock) disable iff (sys_rst)
    wr_start |=> nv_reg == ($past(wr_data_reg) & sfl_pkg::STATUS_WR_MASK)
      ##1 sw_busy_reg;
  endproperty
  a_ro_bits: assert property (p_ro_bits)
    else $error("status write stored read-only bits");

  property p_busy_len;
    @(posedge clock) disable iff (sys_rst)
    $rose(sw_busy_reg) |-> sw_busy_reg [*8];
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("status write busy period too short");

  property p_wrap;
    @(posedge clock) disable iff (sys_rst)
    mem_rd_valid && mem_rd_ready && !fetch_start &&
      mem_rd_addr == sfl_pkg::ADDR_TOP |=> mem_rd_addr == sfl_pkg::ADDR_BASE;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("read address did not wrap to zero");

  property p_read_keeps_latch;
    @(posedge clock) disable iff (sys_rst)
    state_reg == sfl_pkg::ST_DATA_OUT && !ext_write_done && !wr_done |=>
      $stable(latch_reg);
  endproperty
  a_read_keeps_latch: assert property (p_read_keeps_latch)
    else $error("read changed the write latch");
endmodule : sfl_flash_port

//--- hw/sfl_pkg.sv
// Package: opcodes, phase lengths, status layout and timing for the flash port
// Contract
// - Fast read: 0Bh, address, eight dummy bits
// - Dual-output read: 3Bh, single-lane header, two-lane data
// - Dual data: odd bits lane0, even lane1
// - Dual I/O: BBh, two-lane address, four dummies
// - Last two dual dummy clocks: lanes released
// - Address auto-increments, wraps 7FFFFh to 00000h
// - Chip select high ends read, output floats
// - Status read 05h: bit 7 first, falling edges
// - Status byte repeats while clocks continue
// - Status read accepted even while busy
// - Status write 01h plus byte, starts at deselect
// - Status write changes only bits 2-5, 7
// - Writable status bits kept nonvolatile, self-managed
// - Bit 0 reads one while write busy
// - Latch clear blocks erase, program, status write
// - 06h sets latch, 04h clears latch
// - Latch clears at power-on and write completion
// - Rejected writes and reads leave latch alone
// - Clock level at select picks mode 0/3
// - Bytes taken MSB first on rising edges
// - Lock bit plus low guard blocks status writes
package sfl_pkg;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO = 8'hBB;
  localparam logic [7:0] OP_STATUS_RD = 8'h05;
  localparam logic [7:0] OP_STATUS_WR = 8'h01;
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR = 8'h04;

  localparam int ADDR_W = 19;
  localparam logic [18:0] ADDR_TOP = 19'h7FFFF;
  localparam logic [18:0] ADDR_BASE = 19'h00000;

  // Clock counts per phase, compared against a 5-bit counter, then 3-bit shifter reload values
  localparam logic [4:0] OPCODE_CLKS = 5'h08;
  localparam logic [4:0] DATA_BYTE_CLKS = 5'h08;
  localparam logic [4:0] SINGLE_ADDR_CLKS = 5'h18;
  localparam logic [4:0] DUAL_ADDR_CLKS = 5'h0C;
  localparam logic [4:0] SINGLE_DUMMY_CLKS = 5'h08;
  localparam logic [4:0] DUAL_DUMMY_CLKS = 5'h04;
  localparam logic [2:0] SINGLE_BIT_LAST = 3'h7;
  localparam logic [2:0] DUAL_PAIR_LAST = 3'h3;

  // Status byte layout
  localparam int ST_WIP_BIT = 0;
  localparam int ST_LATCH_BIT = 1;
  localparam int ST_PROT_LO = 2;
  localparam int ST_PROT_HI = 5;
  localparam int ST_RSVD_BIT = 6;
  localparam int ST_LOCK_BIT = 7;
  localparam logic [7:0] STATUS_WR_MASK = 8'hBC;
  localparam logic [7:0] NV_RESET = 8'h00;

  // Status write busy time and its cycle count (rounded up)
  localparam int CLOCK_PERIOD_PS = 4000;
  localparam int STATUS_WRITE_TIME_NS = 5000;
  localparam int STATUS_WRITE_CYCLES =
    (STATUS_WRITE_TIME_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_CMD = 8'h02,
    ST_ADDR = 8'h04,
    ST_DUMMY = 8'h08,
    ST_DATA_OUT = 8'h10,
    ST_STATUS_OUT = 8'h20,
    ST_WR_DATA = 8'h40,
    ST_IGNORE = 8'h80
  } sfl_state_e;
endpackage : sfl_pkg

//--- hw/sfl_sync2.sv
// Two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
module sfl_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : sfl_sync2

//--- hw/sfl_buf2.sv
// Two-entry valid/ready buffer with flush, between array and shifter
`timescale 1ns/1ps
module sfl_buf2 #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] entry_reg [2];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count
  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data = entry_reg[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage written by index
  always_ff @(posedge clock) begin
    if (push) begin
      entry_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and count; flush drops stale prefetched bytes
  always_ff @(posedge clock) begin
    if (sys_rst || flush) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : sfl_buf2

//--- testbench/sfl_host_model.sv
// SPI host model in mode 0 or 3: select, link clock and lane drivers
`timescale 1ns/1ps
module sfl_host_model (
  output logic chip_select_n,
  output logic serial_clock,
  output logic h0,
  output logic h1,
  output logic hoe,
  input wire logic io0,
  input wire logic io1
);
  // Clock stands low and select high outside frames
  initial begin
    chip_select_n = 1'h1;
    serial_clock = 1'h0;
    {h0, h1, hoe} = 3'h0;
  end
  // Clock level at select asks for mode 0 (low) or mode 3 (high)
  task automatic sel(input bit m3 = 1'b0);
    serial_clock = m3;
    #62.5 chip_select_n = 1'h0;
    hoe = 1'h1;
    #250 serial_clock = 1'h0;
  endtask : sel
  // Host lane drivers on or off, for the dual dummy turnaround
  task automatic drive(input bit on);
    hoe = on;
  endtask : drive
  // Host drops its lane drivers when the frame ends
  task automatic desel();
    #62.5 chip_select_n = 1'h1;
    hoe = 1'h0;
    #500;
  endtask : desel
  // Eight bits out and in, MSB first; dual sends odd bits on lane1
  task automatic bits(input logic [7:0] tx, input bit dual,
                      output logic [7:0] rx);
    for (int i = 0; i < 8; i += (dual ? 2 : 1)) begin
      if (dual) {h1, h0} = tx[7-i -: 2];
      else h0 = tx[7-i];
      #62.5 serial_clock = 1'h1;
      if (dual) rx[7-i -: 2] = {io0, io1};
      else rx[7-i] = io1;
      #62.5 serial_clock = 1'h0;
    end
  endtask : bits
endmodule : sfl_host_model

//--- testbench/sfl_flash_port_tb.sv
// Self-checking bench for the flash command port
`timescale 1ns/1ps
module sfl_flash_port_tb;
  logic clock, sys_rst, chip_select_n, serial_clock, write_guard_n;
  logic h0, h1, hoe, out0, oe0_n, out1, oe1_n, io0, io1;
  logic [18:0] mem_rd_addr;
  logic mem_rd_valid, mem_rd_ready, ext_busy, ext_write_done, nv_store;
  logic [7:0] mem_rd_data, nv_bits_in, nv_bits_out, rx, nv, d;
  logic write_latch, write_in_progress, spi_mode3;
  logic [31:0] seed = 32'h00000052;
  logic [31:0] rs;
  int err_total, n_tests, k;
  localparam logic [7:0] MSK = sfl_pkg::STATUS_WR_MASK;
  // Undriven lanes show the inverse of the host's last value
  assign io0 = !oe0_n ? out0 : hoe ? h0 : ~h0;
  assign io1 = !oe1_n ? out1 : hoe ? h1 : ~h1;
  sfl_host_model host (.chip_select_n(chip_select_n),
    .serial_clock(serial_clock), .h0(h0), .h1(h1), .hoe(hoe),
    .io0(io0), .io1(io1));
  sfl_flash_port #(.STATUS_WRITE_CYCLES(1200)) dut (.clock(clock),
    .sys_rst(sys_rst), .chip_select_n(chip_select_n),
    .serial_clock(serial_clock), .write_guard_n(write_guard_n),
    .serial_in_io0_in(io0), .serial_in_io0_out(out0),
    .serial_in_io0_oe_n(oe0_n), .serial_out_io1_in(io1),
    .serial_out_io1_out(out1), .serial_out_io1_oe_n(oe1_n),
    .mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid),
    .mem_rd_ready(mem_rd_ready), .mem_rd_data(mem_rd_data),
    .ext_busy(ext_busy), .ext_write_done(ext_write_done),
    .nv_bits_in(nv_bits_in), .nv_bits_out(nv_bits_out),
    .nv_store(nv_store), .write_latch(write_latch),
    .write_in_progress(write_in_progress), .spi_mode3(spi_mode3));
  always #2 clock = ~clock;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic [7:0] fdat(input logic [18:0] a);
    return a[7:0] ^ a[15:8] ^ {5'h0A, a[18:16]};
  endfunction : fdat
  // Array model stalls at random, so the buffer sees gaps
  always @(negedge clock) begin
    seed <= xs(seed);
    mem_rd_valid <= (seed[1:0] != 2'h0);
    mem_rd_data <= fdat(mem_rd_addr);
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (e !== g) begin
      $display("unexpected %s exp %h got %h", nm, e, g);
      err_total++;
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic frame(input logic [7:0] op, input bit two,
                       input logic [7:0] dat);
    host.sel();
    host.bits(op, 0, rx);
    if (two) host.bits(dat, 0, rx);
    host.desel();
  endtask : frame
  // Two copies of the status byte, bit 7 first
  task automatic stat(input logic [7:0] e, input bit m3 = 1'b0);
    host.sel(m3);
    host.bits(sfl_pkg::OP_STATUS_RD, 0, rx);
    repeat (2) begin
      host.bits(8'h00, 0, rx);
      chk("status", e, rx);
    end
    host.desel();
    chk("mode", m3, spi_mode3);
    $display("status test done");
  endtask : stat
  task automatic rd(input logic [7:0] op, input logic [18:0] a, int n);
    bit dio;
    dio = (op == sfl_pkg::OP_DUAL_IO);
    host.sel();
    host.bits(op, 0, rx);
    for (int s = 16; s >= 0; s -= 8) host.bits(8'({5'h00, a} >> s), dio, rx);
    host.drive(!dio);
    host.bits(8'h00, dio, rx);
    host.drive(1'b0);
    for (int j = 0; j < n; j++) begin
      host.bits(8'h00, op != sfl_pkg::OP_FAST_READ, rx);
      chk("read", fdat(19'(a + j)), rx);
    end
    host.desel();
    chk("float", 2'h3, {oe0_n, oe1_n});
    $display("read %h test done", op);
  endtask : rd
  initial begin
    {clock, sys_rst, write_guard_n} = 3'h3;
    {ext_busy, ext_write_done} = 2'h0;
    nv_bits_in = 8'h5F;
    repeat (10) @(negedge clock);
    sys_rst = 1'h0;
    repeat (5) @(negedge clock);
    nv = 8'h5F & MSK;
    stat(nv);
    chk("mode", 1'h0, spi_mode3);
    frame(sfl_pkg::OP_LATCH_SET, 0, 8'h00);
    stat(nv | 8'h02);
    // Lock bit forced on so the later guard-low write must be refused
    d = seed[7:0] | 8'hC3;
    frame(sfl_pkg::OP_STATUS_WR, 1, d);
    nv = d & MSK;
    stat(nv | 8'h03);
    for (k = 0; k < 3000 && nv_store !== 1'h1; k++) @(negedge clock);
    if (k == 3000) begin
      chk("timeout", 1'h1, 1'h0);
      close_out();
    end
    chk("nv", nv, nv_bits_out);
    stat(nv);
    write_guard_n = 1'h0;
    frame(sfl_pkg::OP_LATCH_SET, 0, 8'h00);
    frame(sfl_pkg::OP_STATUS_WR, 1, 8'h00);
    stat(nv | 8'h02);
    write_guard_n = 1'h1;
    frame(sfl_pkg::OP_LATCH_CLR, 0, 8'h00);
    frame(sfl_pkg::OP_STATUS_WR, 1, 8'h00);
    stat(nv, 1'b1);
    frame(sfl_pkg::OP_LATCH_SET, 0, 8'h00);
    @(negedge clock);
    ext_busy = 1'h1;
    ext_write_done = 1'h1;
    @(negedge clock);
    ext_write_done = 1'h0;
    repeat (4) @(negedge clock);
    chk("busy", 2'h1, {write_latch, write_in_progress});
    ext_busy = 1'h0;
    rd(sfl_pkg::OP_FAST_READ, 19'h7FFFE, 3);
    for (int b = 0; b < 8; b++) begin
      rs = xs(seed);
      rd(b[0] ? sfl_pkg::OP_DUAL_IO : sfl_pkg::OP_DUAL_OUT, rs[18:0], 2);
    end
    close_out();
  end
endmodule : sfl_flash_port_tb
